// ### hw/gpio_cn_pkg.sv
// Constants, register map and helpers for the I/O port groups and change notification
//
// Summary of operation
// - Enabled input change raises interrupt request
// - Change detection works with clocks stopped
// - Twenty-two individually enabled notification inputs
// - Notify enables at 00C0/00C2, reset zero
// - Pull-up enables at 00C4/00C6, reset zero
// - Groups B and D: sixteen bits, inputs
// - Group E: pins 9..0, direction 03FF
// - Group F: pins 8..0, direction 01FF
// - Group G: pins 9..6, 3..0 set
// - Latch and pin-level registers reset zero
// - Pin-level read gives pins, write sets latch
// - Direction one is input, zero drives latch
// - Unimplemented bits inert and read zero
`default_nettype none

package gpio_cn_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NUM_GROUPS = 7;
    localparam int REG_W = 16;
    localparam int IDX_W = 10;
    localparam int ADDR_W = 12;
    localparam int NOTIFY_W_DEF = 22;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_CN_EN_LO = 10'h0c0;
    localparam logic [IDX_W-1:0] IDX_CN_EN_HI = 10'h0c2;
    localparam logic [IDX_W-1:0] IDX_PU_EN_LO = 10'h0c4;
    localparam logic [IDX_W-1:0] IDX_PU_EN_HI = 10'h0c6;

    // Group order A, B, C, D, E, F, G
    localparam logic [IDX_W-1:0] DIR_IDX [NUM_GROUPS] =
        '{10'h2c0, 10'h2c6, 10'h2cc, 10'h2d2, 10'h2d8, 10'h2ee, 10'h2e4};
    localparam logic [IDX_W-1:0] PIN_IDX [NUM_GROUPS] =
        '{10'h2c2, 10'h2c8, 10'h2ce, 10'h2d4, 10'h2da, 10'h2e0, 10'h2e6};
    localparam logic [IDX_W-1:0] LAT_IDX [NUM_GROUPS] =
        '{10'h2c4, 10'h2cb, 10'h2d0, 10'h2d6, 10'h2dc, 10'h2e2, 10'h2e8};

    // ----------------------------------------------------------------
    // Implemented pins and reset values
    // ----------------------------------------------------------------
    localparam logic [REG_W-1:0] PIN_MASK [NUM_GROUPS] =
        '{16'hc600, 16'hffff, 16'he00a, 16'hffff, 16'h03ff, 16'h01ff, 16'h03cf};
    localparam logic [REG_W-1:0] DIR_RST [NUM_GROUPS] =
        '{16'hc600, 16'hffff, 16'he00a, 16'hffff, 16'h03ff, 16'h01ff, 16'h03cf};
    localparam logic [REG_W-1:0] LAT_RST = 16'h0000;
    localparam logic [REG_W-1:0] PIN_RST = 16'h0000;
    localparam logic [REG_W-1:0] CN_RST = 16'h0000;
    localparam logic [REG_W-1:0] FULL_MASK = 16'hffff;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Byte-lane write merge, limited to implemented bits
    function automatic logic [REG_W-1:0] merge_write(
        input logic [REG_W-1:0] old,
        input logic [REG_W-1:0] wdata,
        input logic [1:0] strb,
        input logic [REG_W-1:0] mask
    );
        logic [REG_W-1:0] lanes;
        lanes = {{8{strb[1]}}, {8{strb[0]}}};
        return ((old & ~lanes) | (wdata & lanes)) & mask;
    endfunction

    // Word index hit test
    function automatic logic idx_hit(
        input logic [ADDR_W-1:0] addr,
        input logic [IDX_W-1:0] idx
    );
        return addr[ADDR_W-1:2] == idx;
    endfunction

endpackage

`default_nettype wire

// ### hw/notify_if.sv
// Carrier between the register block and the change notification unit
`default_nettype none

interface notify_if #(parameter int NOTIFY_W = 22);
    logic [NOTIFY_W-1:0] level;
    logic [NOTIFY_W-1:0] enable;
    logic irq;
    logic wake;

    modport unit (input level, input enable, output irq, output wake);
    modport host (output level, output enable, input irq, input wake);
endinterface

`default_nettype wire

// ### hw/change_notify.sv
// Change-of-state detector for the notification inputs
`default_nettype none

module change_notify #(
    parameter int NOTIFY_W = 22
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link to register block
    notify_if.unit nfy
);
    import gpio_cn_pkg::*;

    logic [NOTIFY_W-1:0] prev_r;
    logic primed_r;
    logic irq_r;
    logic [NOTIFY_W-1:0] mismatch;

    // ----------------------------------------------------------------
    // Comparison
    // ----------------------------------------------------------------
    // Pure gates, so a change is seen with the clock stopped
    assign mismatch = primed_r ? (nfy.enable & (nfy.level ^ prev_r)) : '0;
    assign nfy.wake = |mismatch;
    assign nfy.irq = irq_r;

    // ----------------------------------------------------------------
    // Previous sample
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_r <= '0;
            primed_r <= 1'b0;
        end else begin
            prev_r <= nfy.level;
            primed_r <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Request pulse
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |mismatch;
        end
    end

endmodule // change_notify

`default_nettype wire

// ### hw/gpio_ports.sv
// Port groups A to G with APB registers and change notification
//
// Chosen here: the APB slave port.
`default_nettype none

module gpio_ports #(
    parameter int NOTIFY_W = gpio_cn_pkg::NOTIFY_W_DEF
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,

    // APB slave
    input wire logic [gpio_cn_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,

    // Port pins, one row per group A..G
    input wire logic [gpio_cn_pkg::NUM_GROUPS-1:0][gpio_cn_pkg::REG_W-1:0] pin_in,
    output logic [gpio_cn_pkg::NUM_GROUPS-1:0][gpio_cn_pkg::REG_W-1:0] pin_out,
    output logic [gpio_cn_pkg::NUM_GROUPS-1:0][gpio_cn_pkg::REG_W-1:0] pin_oe,

    // Notification pads
    input wire logic [NOTIFY_W-1:0] notify_in,
    output logic [NOTIFY_W-1:0] notify_pullup_en,

    // Toward processor
    output logic notify_irq,
    output logic notify_wake
);
    import gpio_cn_pkg::*;

    // ----------------------------------------------------------------
    // Parameter check
    // ----------------------------------------------------------------
    // High registers hold inputs from 16 up; 32 at most fit two halves
    if (NOTIFY_W < 17 || NOTIFY_W > 32) begin : g_bad_width
        $error("NOTIFY_W must lie between 17 and 32");
    end

    localparam int HI_W = NOTIFY_W - REG_W;
    localparam logic [REG_W-1:0] HI_MASK = REG_W'((32'h1 << HI_W) - 32'h1);

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum {
        PH_IDLE,
        PH_SETUP,
        PH_ACCESS
    } apb_phase_t;

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [REG_W-1:0] dir_r [NUM_GROUPS];
    logic [REG_W-1:0] lat_r [NUM_GROUPS];
    logic [REG_W-1:0] pin_r [NUM_GROUPS];
    logic [NOTIFY_W-1:0] cn_en_r;
    logic [NOTIFY_W-1:0] pu_en_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    apb_phase_t phase_r;
    apb_phase_t phase_nxt;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    logic setup_cyc;
    logic wr_cyc;
    logic [REG_W-1:0] wdata16;
    logic [1:0] wstrb;
    logic [REG_W-1:0] rd_val;
    logic rd_hit;

    assign setup_cyc = psel & ~penable;
    assign wr_cyc = (phase_r == PH_ACCESS) & psel & penable & pwrite & ~pslverr_r;
    assign wdata16 = pwdata[REG_W-1:0];
    assign wstrb = pstrb[1:0];

    // Zero wait states: every access phase completes at once
    assign pready = 1'b1;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;

    // ----------------------------------------------------------------
    // Bus phase tracker
    // ----------------------------------------------------------------
    always_comb begin
        phase_nxt = phase_r;
        case (phase_r)
            PH_IDLE: begin
                if (setup_cyc) begin
                    phase_nxt = PH_ACCESS;
                end
            end
            PH_SETUP: begin
                phase_nxt = PH_ACCESS;
            end
            PH_ACCESS: begin
                if (setup_cyc) begin
                    phase_nxt = PH_ACCESS;
                end else begin
                    phase_nxt = PH_IDLE;
                end
            end
            default: begin
                phase_nxt = PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_r <= PH_IDLE;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Read multiplexer
    // ----------------------------------------------------------------
    always_comb begin
        rd_val = '0;
        rd_hit = 1'b0;
        if (idx_hit(paddr, IDX_CN_EN_LO)) begin
            rd_val = cn_en_r[REG_W-1:0];
            rd_hit = 1'b1;
        end
        if (idx_hit(paddr, IDX_CN_EN_HI)) begin
            rd_val = REG_W'(cn_en_r[NOTIFY_W-1:REG_W]);
            rd_hit = 1'b1;
        end
        if (idx_hit(paddr, IDX_PU_EN_LO)) begin
            rd_val = pu_en_r[REG_W-1:0];
            rd_hit = 1'b1;
        end
        if (idx_hit(paddr, IDX_PU_EN_HI)) begin
            rd_val = REG_W'(pu_en_r[NOTIFY_W-1:REG_W]);
            rd_hit = 1'b1;
        end
        for (int g = 0; g < NUM_GROUPS; g++) begin
            if (idx_hit(paddr, DIR_IDX[g])) begin
                rd_val = dir_r[g] & PIN_MASK[g];
                rd_hit = 1'b1;
            end
            if (idx_hit(paddr, PIN_IDX[g])) begin
                rd_val = pin_r[g] & PIN_MASK[g];
                rd_hit = 1'b1;
            end
            if (idx_hit(paddr, LAT_IDX[g])) begin
                rd_val = lat_r[g] & PIN_MASK[g];
                rd_hit = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Read data and error, captured in the setup cycle
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= '0;
            pslverr_r <= 1'b0;
        end else if (setup_cyc) begin
            prdata_r <= pwrite ? 32'h0000_0000 : {16'h0000, rd_val};
            pslverr_r <= ~rd_hit;
        end
    end

    // ----------------------------------------------------------------
    // Notification enable registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cn_en_r <= NOTIFY_W'({CN_RST, CN_RST});
        end else if (wr_cyc) begin
            if (idx_hit(paddr, IDX_CN_EN_LO)) begin
                cn_en_r[REG_W-1:0] <= merge_write(cn_en_r[REG_W-1:0], wdata16, wstrb, FULL_MASK);
            end
            if (idx_hit(paddr, IDX_CN_EN_HI)) begin
                cn_en_r[NOTIFY_W-1:REG_W] <= HI_W'(merge_write(REG_W'(cn_en_r[NOTIFY_W-1:REG_W]),
                    wdata16, wstrb, HI_MASK));
            end
        end
    end

    // ----------------------------------------------------------------
    // Pull-up enable registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pu_en_r <= NOTIFY_W'({CN_RST, CN_RST});
        end else if (wr_cyc) begin
            if (idx_hit(paddr, IDX_PU_EN_LO)) begin
                pu_en_r[REG_W-1:0] <= merge_write(pu_en_r[REG_W-1:0], wdata16, wstrb, FULL_MASK);
            end
            if (idx_hit(paddr, IDX_PU_EN_HI)) begin
                pu_en_r[NOTIFY_W-1:REG_W] <= HI_W'(merge_write(REG_W'(pu_en_r[NOTIFY_W-1:REG_W]),
                    wdata16, wstrb, HI_MASK));
            end
        end
    end

    // Pad pull-up control follows its bit alone
    assign notify_pullup_en = pu_en_r;

    // ----------------------------------------------------------------
    // Direction registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int g = 0; g < NUM_GROUPS; g++) begin
                dir_r[g] <= DIR_RST[g];
            end
        end else if (wr_cyc) begin
            for (int g = 0; g < NUM_GROUPS; g++) begin
                if (idx_hit(paddr, DIR_IDX[g])) begin
                    dir_r[g] <= merge_write(dir_r[g], wdata16, wstrb, PIN_MASK[g]);
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Output latch registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int g = 0; g < NUM_GROUPS; g++) begin
                lat_r[g] <= LAT_RST;
            end
        end else if (wr_cyc) begin
            for (int g = 0; g < NUM_GROUPS; g++) begin
                // Writing the pin-level word lands in the latch
                if (idx_hit(paddr, LAT_IDX[g]) || idx_hit(paddr, PIN_IDX[g])) begin
                    lat_r[g] <= merge_write(lat_r[g], wdata16, wstrb, PIN_MASK[g]);
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin level sampling
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int g = 0; g < NUM_GROUPS; g++) begin
                pin_r[g] <= PIN_RST;
            end
        end else begin
            for (int g = 0; g < NUM_GROUPS; g++) begin
                pin_r[g] <= pin_in[g] & PIN_MASK[g];
            end
        end
    end

    // ----------------------------------------------------------------
    // Pad drive
    // ----------------------------------------------------------------
    always_comb begin
        for (int g = 0; g < NUM_GROUPS; g++) begin
            pin_out[g] = lat_r[g] & PIN_MASK[g];
            pin_oe[g] = ~dir_r[g] & PIN_MASK[g];
        end
    end

    // ----------------------------------------------------------------
    // Change notification unit
    // ----------------------------------------------------------------
    notify_if #(.NOTIFY_W(NOTIFY_W)) nfy ();

    assign nfy.level = notify_in;
    assign nfy.enable = cn_en_r;
    assign notify_irq = nfy.irq;
    assign notify_wake = nfy.wake;

    change_notify #(
        .NOTIFY_W(NOTIFY_W)
    ) u_change_notify (
        .pclk(pclk),
        .presetn(presetn),
        .nfy(nfy)
    );

endmodule // gpio_ports

`default_nettype wire

// ### tb/gpio_ports_assertions.sv
// Port-level checks for the I/O port block
`default_nettype none

module gpio_ports_assertions #(
    parameter int NOTIFY_W = gpio_cn_pkg::NOTIFY_W_DEF
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [gpio_cn_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Port pins
    input wire logic [gpio_cn_pkg::NUM_GROUPS-1:0][gpio_cn_pkg::REG_W-1:0] pin_in,
    input wire logic [gpio_cn_pkg::NUM_GROUPS-1:0][gpio_cn_pkg::REG_W-1:0] pin_out,
    input wire logic [gpio_cn_pkg::NUM_GROUPS-1:0][gpio_cn_pkg::REG_W-1:0] pin_oe,
    // Notification
    input wire logic [NOTIFY_W-1:0] notify_in,
    input wire logic [NOTIFY_W-1:0] notify_pullup_en,
    input wire logic notify_irq,
    input wire logic notify_wake
);
    timeunit 1ns;
    timeprecision 1ps;
    import gpio_cn_pkg::*;

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    logic [IDX_W-1:0] idx;
    logic mapped;
    logic wr_full;
    assign idx = paddr[ADDR_W-1:2];
    assign wr_full = psel && penable && pwrite && (pstrb[1:0] == 2'b11);
    always_comb begin
        mapped = idx inside {IDX_CN_EN_LO, IDX_CN_EN_HI, IDX_PU_EN_LO, IDX_PU_EN_HI};
        for (int g = 0; g < NUM_GROUPS; g++) begin
            mapped = mapped | (idx == DIR_IDX[g]) | (idx == PIN_IDX[g]) | (idx == LAT_IDX[g]);
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_unmapped_err;
        psel && !penable && !mapped |=> pslverr && prdata == 32'h0000_0000;
    endproperty
    a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not refused");
    property p_mapped_read;
        psel && !penable && mapped |=> !pslverr && prdata[31:16] == 16'h0000;
    endproperty
    a_mapped_read: assert property (p_mapped_read) else $error("mapped access refused");
    property p_reset_pins;
        $rose(presetn) |-> pin_oe == '0 && pin_out == '0 && notify_pullup_en == '0;
    endproperty
    a_reset_pins: assert property (p_reset_pins) else $error("pads not idle after reset");
    property p_pullup;
        wr_full && idx == IDX_PU_EN_LO |=> notify_pullup_en[15:0] == $past(pwdata[15:0]);
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up control wrong");
    property p_irq_cause;
        notify_irq |-> $past(notify_wake);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt without change");
    property p_wake_irq;
        notify_wake && $past(presetn) |=> notify_irq;
    endproperty
    a_wake_irq: assert property (p_wake_irq) else $error("change without interrupt");
    for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_grp
        property p_dir_oe;
            wr_full && idx == DIR_IDX[g] |=> pin_oe[g] == (~$past(pwdata[15:0]) & PIN_MASK[g]);
        endproperty
        a_dir_oe: assert property (p_dir_oe) else $error("direction not on drivers");
        property p_lat_out;
            wr_full && (idx == LAT_IDX[g] || idx == PIN_IDX[g])
                |=> pin_out[g] == ($past(pwdata[15:0]) & PIN_MASK[g]);
        endproperty
        a_lat_out: assert property (p_lat_out) else $error("latch not on pads");
        property p_pad_mask;
            ((pin_oe[g] | pin_out[g]) & ~PIN_MASK[g]) == 16'h0000;
        endproperty
        a_pad_mask: assert property (p_pad_mask) else $error("missing pin driven");
    end
endmodule // gpio_ports_assertions

`default_nettype wire

// ### tb/pad_model.sv
// Pad model for port pins and notification inputs
`default_nettype none

module pad_model #(
    parameter int NOTIFY_W = gpio_cn_pkg::NOTIFY_W_DEF
) (
    // Port pads
    input wire logic [gpio_cn_pkg::NUM_GROUPS-1:0][gpio_cn_pkg::REG_W-1:0] pin_out,
    input wire logic [gpio_cn_pkg::NUM_GROUPS-1:0][gpio_cn_pkg::REG_W-1:0] pin_oe,
    input wire logic [gpio_cn_pkg::NUM_GROUPS-1:0][gpio_cn_pkg::REG_W-1:0] ext_level,
    output logic [gpio_cn_pkg::NUM_GROUPS-1:0][gpio_cn_pkg::REG_W-1:0] pin_in,
    // Notification pads
    input wire logic [NOTIFY_W-1:0] notify_drv,
    input wire logic [NOTIFY_W-1:0] notify_float,
    input wire logic [NOTIFY_W-1:0] notify_pullup_en,
    output logic [NOTIFY_W-1:0] notify_in
);
    timeunit 1ns;
    timeprecision 1ps;
    import gpio_cn_pkg::*;

    // Enabled driver wins, else the outside level
    always_comb begin
        for (int g = 0; g < NUM_GROUPS; g++) begin
            pin_in[g] = (pin_oe[g] & pin_out[g]) | (~pin_oe[g] & ext_level[g]);
        end
    end
    // Released pad reads high only with its pull-up on
    assign notify_in = (notify_float & notify_pullup_en) | (~notify_float & notify_drv);
endmodule // pad_model

`default_nettype wire

// ### tb/gpio_ports_tb_top.sv
// Self-checking bench for the I/O port block
`default_nettype none

module gpio_ports_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import gpio_cn_pkg::*;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    localparam int NW = 22;
    localparam logic [15:0] MASK [7] = '{16'hc600, 16'hffff, 16'he00a, 16'hffff, 16'h03ff, 16'h01ff, 16'h03cf};
    logic [IDX_W-1:0] cn_idx [4] = '{IDX_CN_EN_LO, IDX_CN_EN_HI, IDX_PU_EN_LO, IDX_PU_EN_HI};
    int flip [4] = '{3, 4, 21, 16};
    int exp_irq [4] = '{1, 0, 1, 0};
    logic pclk = 1'b0;
    logic clk_run = 1'b1;
    logic presetn = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = '0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [NUM_GROUPS-1:0][REG_W-1:0] pin_in;
    logic [NUM_GROUPS-1:0][REG_W-1:0] pin_out;
    logic [NUM_GROUPS-1:0][REG_W-1:0] pin_oe;
    logic [NUM_GROUPS-1:0][REG_W-1:0] ext_level = '0;
    logic [NW-1:0] notify_in;
    logic [NW-1:0] notify_pullup_en;
    logic [NW-1:0] notify_drv = '0;
    logic [NW-1:0] notify_float = '0;
    logic notify_irq;
    logic notify_wake;
    int n_mismatch = 0;
    int check_count = 0;
    int irq_cnt = 0;
    int base;
    logic [31:0] rd;
    logic err;

    always #10 pclk = clk_run ? ~pclk : pclk;
    always @(negedge pclk) if (notify_irq === 1'b1) irq_cnt++;

    gpio_ports #(.NOTIFY_W(NW)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .notify_in(notify_in), .notify_pullup_en(notify_pullup_en), .notify_irq(notify_irq),
        .notify_wake(notify_wake));
    pad_model #(.NOTIFY_W(NW)) u_pads (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
        .pin_in(pin_in), .notify_drv(notify_drv), .notify_float(notify_float),
        .notify_pullup_en(notify_pullup_en), .notify_in(notify_in));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic xfer(input logic [IDX_W-1:0] idx, input logic wr, input logic [15:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= {idx, 2'b00};
        pwrite <= wr;
        pwdata <= {16'h0000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd_chk(input string what, input logic [IDX_W-1:0] idx, input logic [15:0] exp);
        xfer(idx, 1'b0, 16'h0000);
        chk(what, {16'h0000, exp}, rd);
        chk("read error flag", 32'h0, {31'h0, err});
    endtask

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (cn_idx[i]) rd_chk("notify register reset", cn_idx[i], 16'h0000);
        for (int g = 0; g < NUM_GROUPS; g++) begin
            rd_chk("direction reset", DIR_IDX[g], MASK[g]);
            rd_chk("latch reset", LAT_IDX[g], 16'h0000);
            rd_chk("pin level reset", PIN_IDX[g], 16'h0000);
            xfer(LAT_IDX[g], 1'b1, 16'hffff);
            rd_chk("latch masked", LAT_IDX[g], MASK[g]);
            chk("inputs keep driver off", 32'h0, {16'h0, pin_oe[g]});
            ext_level[g] <= 16'h5a3c;
            @(posedge pclk);
            rd_chk("pin level of inputs", PIN_IDX[g], 16'h5a3c & MASK[g]);
            xfer(DIR_IDX[g], 1'b1, 16'hffff);
            rd_chk("direction masked", DIR_IDX[g], MASK[g]);
            xfer(DIR_IDX[g], 1'b1, 16'h0000);
            chk("outputs drive", {16'h0, MASK[g]}, {16'h0, pin_oe[g]});
            chk("latch on pads", {16'h0, MASK[g]}, {16'h0, pin_out[g]});
            xfer(PIN_IDX[g], 1'b1, 16'h0f0f);
            rd_chk("pin write lands in latch", LAT_IDX[g], 16'h0f0f & MASK[g]);
            rd_chk("pin level of outputs", PIN_IDX[g], 16'h0f0f & MASK[g]);
        end
        xfer(10'h0c8, 1'b1, 16'hffff);
        chk("unmapped write error", 32'h1, {31'h0, err});
        xfer(10'h0c8, 1'b0, 16'h0000);
        chk("unmapped read data", 32'h0, rd);
        xfer(IDX_CN_EN_LO, 1'b1, 16'h0009);
        xfer(IDX_CN_EN_HI, 1'b1, 16'h0020);
        rd_chk("notify enable high", IDX_CN_EN_HI, 16'h0020);
        xfer(IDX_PU_EN_LO, 1'b1, 16'h8001);
        xfer(IDX_PU_EN_HI, 1'b1, 16'h0020);
        rd_chk("pull-up enable high", IDX_PU_EN_HI, 16'h0020);
        chk("pull-up controls", 32'h0020_8001, {10'h0, notify_pullup_en});
        foreach (flip[i]) begin
            base = irq_cnt;
            notify_drv[flip[i]] <= ~notify_drv[flip[i]];
            repeat (4) @(posedge pclk);
            chk("interrupt pulses", 32'(exp_irq[i]), 32'(irq_cnt - base));
        end
        // Released pad 0 is lifted by its pull-up, which counts as a change
        base = irq_cnt;
        notify_float[0] <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("released pad pulled up", 32'h1, 32'(irq_cnt - base));
        @(negedge pclk);
        clk_run = 1'b0;
        base = irq_cnt;
        notify_drv[3] <= ~notify_drv[3];
        #50;
        chk("wake without clock", 32'h1, {31'h0, notify_wake});
        clk_run = 1'b1;
        repeat (4) @(posedge pclk);
        chk("interrupt after wake", 32'h1, 32'(irq_cnt - base));
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("pull-ups after reset", 32'h0, {10'h0, notify_pullup_en});
        chk("drivers off after reset", 32'h0, {16'h0, pin_oe[1]});
        end_sim();
    end

    initial begin
        #100000;
        n_mismatch++;
        end_sim();
    end
endmodule // gpio_ports_tb_top

bind gpio_ports gpio_ports_assertions #(.NOTIFY_W(NOTIFY_W)) u_chk (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .notify_in(notify_in), .notify_pullup_en(notify_pullup_en),
    .notify_irq(notify_irq), .notify_wake(notify_wake));

`default_nettype wire
